// >>> design/bin_sequencer.sv
// Handler binning output sequencer with a classic Wishbone register slave.
// Notes on behaviour
// [RL1] Pulse handler: one of four lines pulses.
// [RL2] Low-pulse handler: lines idle high.
// [RL3] High-pulse handler: lines idle low.
// [RL4] Register handler: code on 1-3, strobe 4.
// [RL5] Handler latches code on strobe edge.
// [RL6] Low strobe: line 4 idles high.
// [RL7] High strobe: line 4 idles low.
// [RL8] Busy mode: line 4 high during test.
// [RL9] Inverted busy: line 4 low during test.
// [RL10] Strobe for register, busy for pulse handlers.
// [RL11] Auto-clear restores idle, else software does.
// [RL12] Busy modes force line 4 idle level.
// [RL13] Hold delay 0-60 s, 10 us steps.
// [RL14] Lines 1-3 hold 20 us longer.
// [RL15] Code settles 10 us before strobe.
// [RL16] Arm event matches start pulse polarity.
// [RL17] Four outputs, one start input.
// [RL18] Strobe ends 10 us before code.
// [RL19] Arm on falling, rising or either edge.
// [RL20] Pattern bit n drives line n+1.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module bin_sequencer
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Handler port.
  input wire logic test_begin_input_i,
  output logic [3:0] lines_o
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic ack_reg;                   // Bus acknowledge.
  logic [31:0] rdata_reg;          // Registered read data.
  logic [CTRL_W-1:0] ctrl_reg;     // Auto-clear, line 4 and arm selects.
  logic [3:0] idle_reg;            // Programmed idle pattern.
  logic [3:0] outcome_reg;         // Last outcome pattern written during a test.
  logic [DELAY_W-1:0] delay_reg;   // Hold delay in 10 us steps.
  logic start_seen_reg;            // Sticky: an arm event was taken.
  logic [3:0] lines_reg;           // Registered line levels.
  logic [DELAY_W-1:0] step_cnt_reg; // Steps spent in the strobe phase.
  logic [31:0] phase_cnt_reg;      // Cycles in the present state.
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [3:0] lines_next;
  logic wr_take;                   // Write takes effect this edge.
  logic hit_outcome;
  logic hit_command;
  logic clear_after_delay_enable;
  l4_mode_t line_four_function_select;
  logic l4_idle;                   // Idle level of line 4.
  logic l4_active;                 // Busy level of line 4.
  logic soft_start;
  logic restore_cmd;

  seq_link_if link ();

  // Merges a write into a register honouring the byte lanes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] lanes);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Helper units.

  // Start input is taken as already synchronous to clk_i.
  assign link.begin_level = test_begin_input_i;  // [RL17]
  assign link.arm_sel = arm_sel_t'(ctrl_reg[CTRL_ARM_LSB +: 2]);
  // Each new outcome restarts the step so the setup is a full 10 us.
  assign link.step_restart = (state_reg == ST_BUSY) && hit_outcome;

  arm_detect u_arm
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link(link)
  );

  step_timer #(.CYCLES(STEP_CYC)) u_step
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link(link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  // Writes land on the edge where the master samples ack high.
  assign wr_take = cyc_i && stb_i && we_i && ack_reg;
  assign hit_outcome = wr_take && (adr_i == OFS_OUTCOME) && sel_i[0];
  assign hit_command = wr_take && (adr_i == OFS_COMMAND) && sel_i[0];
  assign soft_start = hit_command && dat_i[CMD_START_BIT];
  assign restore_cmd = hit_command && dat_i[CMD_RESTORE_BIT];
  assign clear_after_delay_enable = ctrl_reg[CTRL_AUTOCLR_BIT];
  assign line_four_function_select = l4_mode_t'(ctrl_reg[CTRL_L4_LSB +: 2]);

  // Ack comes one cycle after the request and drops the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= cyc_i && stb_i && !ack_reg;
  end

  // Read data is captured as ack rises; unmapped offsets read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h00000000;
    else if (cyc_i && stb_i && !ack_reg)
    begin
      case (adr_i)
        OFS_CTRL: rdata_reg <= {27'h0, ctrl_reg};
        OFS_IDLE: rdata_reg <= {28'h0000000, idle_reg};
        OFS_OUTCOME: rdata_reg <= {28'h0000000, outcome_reg};
        OFS_DELAY: rdata_reg <= {9'h0, delay_reg};
        OFS_STATUS:
          rdata_reg <= {24'h000000, lines_reg,
                        state_reg == ST_SHOW,
                        state_reg inside {ST_SETUP, ST_STROBE, ST_TAIL},
                        state_reg == ST_BUSY,
                        start_seen_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Configuration registers; delays beyond 60 s are clamped.
  always_ff @(posedge clk_i)
  begin
    logic [31:0] m;
    m = 32'h00000000;
    if (rst_i)
    begin
      ctrl_reg <= CTRL_RST;
      idle_reg <= IDLE_RST;
      delay_reg <= DELAY_RST;
    end
    else if (wr_take)
    begin
      case (adr_i)
        OFS_CTRL:
        begin
          m = merge({27'h0, ctrl_reg}, dat_i, sel_i);
          ctrl_reg <= m[CTRL_W-1:0];
        end
        OFS_IDLE:
        begin
          m = merge({28'h0000000, idle_reg}, dat_i, sel_i);
          idle_reg <= m[3:0];
        end
        OFS_DELAY:
        begin
          m = merge({9'h0, delay_reg}, dat_i, sel_i);
          if (m > 32'(HOLD_MAX_STEPS))
            delay_reg <= DELAY_W'(HOLD_MAX_STEPS);  // [RL13]
          else
            delay_reg <= m[DELAY_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // An outcome is accepted only while a test is in progress.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      outcome_reg <= OUTCOME_RST;
    else if (state_reg == ST_BUSY && hit_outcome)
      outcome_reg <= dat_i[3:0];
  end

  // Sticky start flag, cleared by writing one; a new event wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_seen_reg <= 1'b0;
    else if (link.arm_evt || (state_reg == ST_IDLE && soft_start))
      start_seen_reg <= 1'b1;
    else if (wr_take && adr_i == OFS_STATUS && sel_i[0] &&
             dat_i[STAT_START_SEEN_BIT])
      start_seen_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Busy modes pin line 4 regardless of the idle pattern.
  assign l4_idle = (line_four_function_select == L4_BUSY) ? 1'b0 :
                   (line_four_function_select == L4_BUSY_N) ? 1'b1 :
                   idle_reg[3];  // [RL12] [RL6] [RL7] [RL10]
  // The busy level is the opposite of the forced idle level.
  assign l4_active = (line_four_function_select inside {L4_BUSY, L4_BUSY_N})
                     ? ~l4_idle : l4_idle;  // [RL8] [RL9]

  // Test flow: wait, busy, then setup, strobe and tail of 10 us steps.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (link.arm_evt || (link.arm_sel == ARM_SOFT && soft_start))
          state_next = ST_BUSY;  // [RL16] [RL19]
      ST_BUSY:
        if (hit_outcome)
          state_next = ST_SETUP;
      ST_SETUP:
        if (link.step_tick)
        begin
          // Without auto-clear the pattern simply stays up.
          if (!clear_after_delay_enable)
            state_next = ST_SHOW;  // [RL11]
          else if (delay_reg == '0)
            state_next = ST_TAIL;
          else
            state_next = ST_STROBE;  // [RL15]
        end
      ST_STROBE:
        if (link.step_tick && step_cnt_reg == delay_reg - 1'b1)
          state_next = ST_TAIL;  // [RL13]
      ST_TAIL:
        if (link.step_tick)
          state_next = ST_IDLE;  // [RL11] [RL14] [RL18]
      ST_SHOW:
        if (restore_cmd)
          state_next = ST_IDLE;  // [RL11]
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Counts whole steps while the strobe stands.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_reg != ST_STROBE)
      step_cnt_reg <= '0;
    else if (link.step_tick)
      step_cnt_reg <= step_cnt_reg + 1'b1;
  end

  // Line levels: bit n of a pattern drives line n+1.
  always_comb
  begin
    lines_next = {l4_idle, idle_reg[2:0]};  // [RL2] [RL3] [RL20]
    case (state_reg)
      ST_BUSY: lines_next = {l4_active, idle_reg[2:0]};  // [RL8] [RL9]
      ST_SETUP, ST_TAIL:
        lines_next = {l4_idle, outcome_reg[2:0]};  // [RL15] [RL18]
      ST_STROBE, ST_SHOW:
      begin
        // Strobe mode puts pattern bit 3 on line 4 as the strobe.
        if (line_four_function_select inside {L4_BUSY, L4_BUSY_N})
          lines_next = {l4_idle, outcome_reg[2:0]};  // [RL1]
        else
          lines_next = outcome_reg;  // [RL4] [RL5] [RL6] [RL7]
      end
      default: ;
    endcase
  end

  // Every output comes straight from a flip-flop.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lines_reg <= IDLE_RST;
    else
      lines_reg <= lines_next;
  end

  assign lines_o = lines_reg;
  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  localparam int LAST_STEP_CYC = STEP_CYC - 1;

  // Cycles spent in the present state, for the phase checks.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_next != state_reg)
      phase_cnt_reg <= 32'h00000000;
    else
      phase_cnt_reg <= phase_cnt_reg + 32'h00000001;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_leave_setup;
    state_reg == ST_SETUP && state_next != ST_SETUP;
  endsequence
  sequence seq_leave_tail;
    state_reg == ST_TAIL && state_next != ST_TAIL;
  endsequence

  chk_setup_width: assert property (  // [RL15]
    seq_leave_setup |-> phase_cnt_reg == LAST_STEP_CYC)
    else $error("Setup phase is not one step long.");
  chk_tail_width: assert property (  // [RL14]
    seq_leave_tail |-> phase_cnt_reg == LAST_STEP_CYC)
    else $error("Tail phase is not one step long.");
  chk_strobe_steps: assert property (  // [RL13]
    state_reg == ST_STROBE && state_next == ST_TAIL
      |-> step_cnt_reg == delay_reg - 1'b1 && link.step_tick)
    else $error("Strobe did not last the hold delay.");
  chk_autoclear_idle: assert property (  // [RL11]
    seq_leave_tail |=> state_reg == ST_IDLE
      ##1 lines_reg[2:0] == idle_reg[2:0])
    else $error("Idle pattern not restored after the tail.");
  chk_busy_high: assert property (  // [RL8]
    state_reg == ST_BUSY && line_four_function_select == L4_BUSY
      |=> lines_reg[3])
    else $error("Line 4 not high during test in busy mode.");
  chk_busy_low: assert property (  // [RL9]
    state_reg == ST_BUSY && line_four_function_select == L4_BUSY_N
      |=> !lines_reg[3])
    else $error("Line 4 not low during test in inverted busy mode.");
  chk_forced_idle: assert property (  // [RL12]
    state_reg == ST_IDLE && line_four_function_select == L4_BUSY
      |=> !lines_reg[3])
    else $error("Line 4 idle level not forced low.");
  chk_code_window: assert property (  // [RL18]
    state_reg == ST_TAIL |=> lines_reg == {l4_idle, outcome_reg[2:0]})
    else $error("Tail does not hold code with line 4 idle.");
  chk_arm_start: assert property (  // [RL19]
    state_reg == ST_IDLE && link.arm_evt |=> state_reg == ST_BUSY)
    else $error("Arm event did not start a test.");
  chk_manual_hold: assert property (  // [RL11]
    state_reg == ST_SHOW && !restore_cmd |=> state_reg == ST_SHOW)
    else $error("Pattern left without a restore command.");

endmodule

// >>> design/seq_pkg.sv
// Constants, field positions and types shared by the binning output sequencer.
package seq_pkg;

  // Clock period and the 10 us step that paces the setup, strobe and tail phases.
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_NS = 10000;
  localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Longest hold delay: 60 s counted in 10 us steps.
  localparam int HOLD_MAX_S = 60;
  localparam int STEPS_PER_S = 1000000000 / STEP_NS;
  localparam int HOLD_MAX_STEPS = HOLD_MAX_S * STEPS_PER_S;
  localparam int DELAY_W = 23;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IDLE = 8'h04;
  localparam logic [7:0] OFS_OUTCOME = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;

  // Control register fields.
  localparam int CTRL_AUTOCLR_BIT = 0;
  localparam int CTRL_L4_LSB = 1;
  localparam int CTRL_ARM_LSB = 3;
  localparam int CTRL_W = 5;

  // Command register fields (write-only strobes).
  localparam int CMD_RESTORE_BIT = 0;
  localparam int CMD_START_BIT = 1;

  // Status register fields.
  localparam int STAT_START_SEEN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SEQ_BIT = 2;
  localparam int STAT_SHOW_BIT = 3;
  localparam int STAT_LINES_LSB = 4;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [3:0] IDLE_RST = 4'hf;
  localparam logic [3:0] OUTCOME_RST = 4'hf;
  localparam logic [DELAY_W-1:0] DELAY_RST = 23'h000000;

  // Function of output line 4.
  typedef enum logic [1:0] {
    L4_STROBE = 2'b00,
    L4_BUSY = 2'b01,
    L4_BUSY_N = 2'b10
  } l4_mode_t;

  // Event that starts a test.
  typedef enum logic [1:0] {
    ARM_FALL = 2'b00,
    ARM_RISE = 2'b01,
    ARM_EITHER = 2'b10,
    ARM_SOFT = 2'b11
  } arm_sel_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_TAIL = 3'b100,
    ST_SHOW = 3'b101
  } seq_state_t;

endpackage

// >>> design/seq_link_if.sv
// Interface joining the sequencer to its arm detector and step timer.
`timescale 1ns/1ps
interface seq_link_if;
  import seq_pkg::*;
  logic begin_level;     // Sampled start input level.
  arm_sel_t arm_sel;     // Selected arm event.
  logic arm_evt;         // One-cycle pulse: a test may begin.
  logic step_restart;    // Restarts the 10 us step count.
  logic step_tick;       // One-cycle pulse at the end of each step.

  modport arm_side (input begin_level, input arm_sel, output arm_evt);
  modport step_side (input step_restart, output step_tick);
endinterface

// >>> design/arm_detect.sv
// Start-input edge detector that raises the selected arm event.
`timescale 1ns/1ps
module arm_detect
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to the sequencer.
  seq_link_if.arm_side link
);
  import seq_pkg::*;

  logic prev_reg;   // Level seen on the previous cycle.
  logic valid_reg;  // Set once prev_reg holds a real sample.
  logic evt_reg;    // Registered arm pulse.

  // Keep the last level; no edge is reported before one real sample.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= link.begin_level;
      valid_reg <= 1'b1;
    end
  end

  // Decode the chosen edge into a single pulse.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_reg <= 1'b0;
    else if (!valid_reg)
      evt_reg <= 1'b0;
    else
    begin
      case (link.arm_sel)
        ARM_FALL: evt_reg <= prev_reg & ~link.begin_level;
        ARM_RISE: evt_reg <= ~prev_reg & link.begin_level;
        ARM_EITHER: evt_reg <= prev_reg ^ link.begin_level;
        default: evt_reg <= 1'b0;
      endcase
    end
  end

  assign link.arm_evt = evt_reg;
endmodule

// >>> design/step_timer.sv
// Divider that gives a one-cycle tick every 10 us, restartable.
`timescale 1ns/1ps
module step_timer
#(
  parameter int CYCLES = seq_pkg::STEP_CYC
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to the sequencer.
  seq_link_if.step_side link
);
  import seq_pkg::*;

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;  // Cycles elapsed in the present step.

  // Restart aligns the first tick to exactly CYCLES cycles later.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || link.step_restart)
      cnt_reg <= '0;
    else if (cnt_reg == LAST)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign link.step_tick = (cnt_reg == LAST) && !link.step_restart;
endmodule

// >>> sim/handler_model.sv
// Behavioural component handler that starts tests and latches bin codes.
`timescale 1ns/1ps
module handler_model
(
  // Clock.
  input wire logic clk_i,
  // Lines from the sequencer.
  input wire logic [3:0] lines_i,
  // Start line back to the sequencer.
  output logic begin_o
);
  logic prev4; // Line 4 one cycle ago.
  logic strobe_low; // High when the strobe goes low.
  logic [2:0] bin_reg; // Last latched bin code.

  ////////////////////////////////////////////////////////////////////////////
  // The start line rests at its not-ready level, always driven.
  initial
  begin
    begin_o = 1'b1;
    strobe_low = 1'b1;
    prev4 = 1'b1;
    bin_reg = 3'h0;
  end

  // Moves to not-ready, pulses the active level, then returns.
  task automatic start_pulse(input logic act);
    @(posedge clk_i);
    begin_o <= ~act;
    repeat (4) @(posedge clk_i);
    begin_o <= act;
    repeat (4) @(posedge clk_i);
    begin_o <= ~act;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Only the active strobe edge latches, so a late code is caught out.
  always @(posedge clk_i)
  begin
    prev4 <= lines_i[3];
    if (strobe_low ? (prev4 && !lines_i[3]) : (!prev4 && lines_i[3]))
    begin
      bin_reg <= lines_i[2:0];
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the binning output sequencer.
`timescale 1ns/1ps
module tb;
  import seq_pkg::*;
  localparam int N = 500; // Cycles in one 10 us step.
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, begin_w;
  logic [7:0] adr_i;
  logic [3:0] sel_i, lines_o, idle, out;
  logic [31:0] dat_i, dat_o, rd;
  int n_fail, comparisons;
  logic [7:0] ra [5]; // Addresses checked after reset.
  logic [31:0] rv [5]; // Their reset values.

  bin_sequencer bin_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .test_begin_input_i(begin_w), .lines_o(lines_o));
  handler_model handler_model_inst (.clk_i(clk_i), .lines_i(lines_o),
    .begin_o(begin_w));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Compares two values and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; the request stands until ack is seen.
  // Only the watchdog ends a wait for an answer that never comes.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // Waits a short bounded time for a line pattern, then checks it.
  task automatic wait_lines(input logic [3:0] v);
    int k;
    k = 0;
    while (lines_o !== v && k < 50)
    begin
      k++;
      @(posedge clk_i);
    end
    chk({28'h0, lines_o}, {28'h0, v});
  endtask

  // Counts how many cycles a pattern stands and compares the count.
  task automatic hold(input logic [3:0] v, input int n);
    int k;
    k = 0;
    while (lines_o === v && k < 8 * N)
    begin
      k++;
      @(posedge clk_i);
    end
    chk(32'(k), 32'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A hang counts as a mismatch; the run needs about 9200 cycles.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    ra = '{OFS_CTRL, OFS_IDLE, OFS_OUTCOME, OFS_DELAY, 8'h40};
    rv = '{32'h0, 32'hf, 32'hf, 32'h0, 32'h0};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({28'h0, lines_o}, 32'hf);
    // Reset values, with an unmapped address reading zero.
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, ra[i], 32'h0, rd);
      chk(rd, rv[i]);
    end
    // An outcome outside a test is ignored.
    wb(1'b1, OFS_OUTCOME, 32'h3, rd);
    wb(1'b0, OFS_OUTCOME, 32'h0, rd);
    chk(rd, 32'hf);
    // The longest delay is 60 s in 10 us steps.
    wb(1'b1, OFS_DELAY, 32'h7fffff, rd);
    wb(1'b0, OFS_DELAY, 32'h0, rd);
    chk(rd, 32'h5b8d80);
    wb(1'b1, OFS_DELAY, 32'h2, rd);
    // Strobe mode, low-going then high-going, falling then rising arm.
    for (int i = 0; i < 2; i++)
    begin
      idle = i ? 4'h0 : 4'hf;
      out = i ? 4'hb : 4'h5;
      wb(1'b1, OFS_IDLE, {28'h0, idle}, rd);
      wb(1'b1, OFS_CTRL, 32'h1 | (i << CTRL_ARM_LSB), rd);
      wait_lines(idle);
      handler_model_inst.strobe_low = ~i[0];
      handler_model_inst.start_pulse(i[0]);
      wb(1'b0, OFS_STATUS, 32'h0, rd);
      chk({31'h0, rd[STAT_BUSY_BIT]}, 32'h1);
      wb(1'b1, OFS_OUTCOME, {28'h0, out}, rd);
      wait_lines({idle[3], out[2:0]});
      hold({idle[3], out[2:0]}, N);
      hold(out, 2 * N);
      hold({idle[3], out[2:0]}, N);
      chk({28'h0, lines_o}, {28'h0, idle});
      chk({29'h0, handler_model_inst.bin_reg}, {29'h0, out[2:0]});
    end
    // Busy mode, high-going pulse handler; idle bit of line 4 overridden.
    wb(1'b1, OFS_IDLE, 32'h8, rd);
    wb(1'b1, OFS_CTRL, 32'h0b, rd);
    wait_lines(4'h0);
    handler_model_inst.start_pulse(1'b1);
    chk({28'h0, lines_o}, 32'h8);
    wb(1'b1, OFS_OUTCOME, 32'h2, rd);
    wait_lines(4'h2);
    hold(4'h2, 4 * N);
    chk({28'h0, lines_o}, 32'h0);
    // Inverted busy, either edge, no auto-clear: software restores idle.
    wb(1'b1, OFS_IDLE, 32'h7, rd);
    wb(1'b1, OFS_CTRL, 32'h14, rd);
    wait_lines(4'hf);
    handler_model_inst.start_pulse(1'b1);
    chk({28'h0, lines_o}, 32'h7);
    wb(1'b1, OFS_OUTCOME, 32'hb, rd);
    wait_lines(4'hb);
    repeat (4 * N) @(posedge clk_i);
    chk({28'h0, lines_o}, 32'hb);
    wb(1'b1, OFS_COMMAND, 32'h1, rd);
    wait_lines(4'hf);
    // Software start with no hold delay: the strobe phase is skipped.
    wb(1'b1, OFS_DELAY, 32'h0, rd);
    wb(1'b1, OFS_IDLE, 32'hf, rd);
    wb(1'b1, OFS_CTRL, 32'h19, rd);
    wb(1'b1, OFS_COMMAND, 32'h2, rd);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd, 32'hf3);
    wb(1'b1, OFS_OUTCOME, 32'h6, rd);
    wait_lines(4'he);
    hold(4'he, 2 * N);
    chk({28'h0, lines_o}, 32'hf);
    // The sticky start flag stays until software writes one to it.
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd, 32'hf1);
    wb(1'b1, OFS_STATUS, 32'h1, rd);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd, 32'hf0);
    give_verdict();
  end
endmodule
